// File: pkg/smi_flag_pkg.sv
// Package for the management interrupt event flag and enable register.
// Assumes a single 64-bit register reached by a model-specific register port.
package smi_flag_pkg;
    localparam int REG_W = 64;
    localparam int SRC_W = 16;
    localparam int FLAG_LSB = 32;
    localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
    // Implemented enable positions; the flag of enable n sits at n + FLAG_LSB
    localparam logic [15:0] ENABLE_MASK = 16'hfbff;
    // Sources that raise the synchronous indication; the rest are asynchronous
    localparam logic [15:0] SYNC_MASK = 16'hdb00;
    localparam logic [15:0] ASYNC_MASK = 16'h20ff;
    localparam int PWR_FIRST_BIT = 15;
    localparam int PWR_SECOND_BIT = 14;
    localparam int KBD_GATE_BIT = 13;
    localparam int LEGACY_XFER_BIT = 12;
    localparam int LOWPIN_BIT = 11;
    localparam int SERIAL_B_BIT = 9;
    localparam int SERIAL_A_BIT = 8;
    localparam int FAST_INIT_BIT = 7;
    localparam int FAST_GATE_BIT = 6;
    localparam int KBD_INIT_BIT = 5;
    localparam int POWER_LOGIC_BIT = 4;
    localparam int IRQ_MAPPER_BIT = 3;
    localparam int KBD_EMU_BIT = 2;
    localparam int SHUTDOWN_BIT = 1;
    localparam int HALT_BIT = 0;

    typedef struct packed {
        logic write;
        logic [63:0] data;
    } reg_req_t;

    typedef struct packed {
        logic sync_mgmt_interrupt;
        logic async_mgmt_interrupt;
    } mgmt_irq_t;
endpackage

// File: design/smi_flag_cell.sv
// One sticky write-1-to-clear event flag with its enable.
// Assumes event strobes are synchronous to clock_in.
`timescale 1ns/100ps
module smi_flag_cell (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Control
    input wire logic enable_in,
    input wire logic event_in,
    input wire logic clear_in,
    // State
    output logic flag_out
);
    logic flag_q;
    logic flag_d;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flag_d = flag_q;
        if (clear_in) begin
            flag_d = 1'b0;
        end
        if (event_in && enable_in) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;
endmodule // smi_flag_cell

// File: design/smi_event_flag_control.sv
// Management interrupt event flags and enables in one 64-bit register.
// Assumes register accesses and source strobes are synchronous to clock_in.
// Operation
// - Reserved bits 63:48, 42, 31:16, 10 read zero, writes ignored.
// - Flags are sticky; writing one clears, zero leaves unchanged.
// - A source sets its flag only while enable bit n is set.
// - First power control write sets flag 47 when enable 15 set.
// - Second power control write sets flag 46 when enable 14 set.
// - Keyboard gate line change sets flag 45 when enable 13 set.
// - Legacy DMA event sets flag 44 when enable 12 set.
// - Low pin count bus event sets flag 43 when enable 11 set.
// - Second serial port event sets flag 41 when enable 9 set.
// - First serial port event sets flag 40 when enable 8 set.
// - Fast port init request sets flag 39 when enable 7 set.
// - Fast port gate change sets flag 38 when enable 6 set.
// - Keyboard init sequence sets flag 37 when enable 5 set.
// - Power logic event sets flag 36 when enable 4 set.
// - Interrupt mapper event sets flag 35 when enable 3 set.
// - Keyboard emulation event sets flag 34 when enable 2 set.
// - Shutdown cycle sets flag 33 when enable 1 set.
// - Halt cycle sets flag 32 when enable 0 set.
`timescale 1ns/100ps
module smi_event_flag_control
    import smi_flag_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Register port
    input wire reg_req_t reg_req_in,
    output logic [63:0] reg_rdata_out,
    // Event strobes, one cycle each
    input wire logic power_ctrl_first_reg_write_in,
    input wire logic power_ctrl_second_reg_write_in,
    input wire logic kbd_gate_line_change_in,
    input wire logic legacy_transfer_event_in,
    input wire logic lowpin_bus_event_in,
    input wire logic serial_b_event_in,
    input wire logic serial_a_event_in,
    input wire logic fast_port_init_in,
    input wire logic fast_port_gate_change_in,
    input wire logic kbd_init_sequence_in,
    input wire logic power_logic_event_in,
    input wire logic irq_mapper_event_in,
    input wire logic kbd_emulation_event_in,
    input wire logic shutdown_cycle_in,
    input wire logic halt_cycle_in,
    // Interrupt indications
    output mgmt_irq_t irq_out
);
    logic [SRC_W-1:0] enable_q;
    logic [SRC_W-1:0] flags;
    logic [SRC_W-1:0] events;
    logic [SRC_W-1:0] clears;
    mgmt_irq_t irq_q;

    // One indication per kind; an enable cleared later drops it but keeps the flag
    function automatic logic any_pending(input logic [SRC_W-1:0] flag_v,
            input logic [SRC_W-1:0] en_v, input logic [SRC_W-1:0] kind_v);
        any_pending = |(flag_v & en_v & kind_v);
    endfunction

    always_comb begin
        events = '0;
        events[PWR_FIRST_BIT] = power_ctrl_first_reg_write_in;
        events[PWR_SECOND_BIT] = power_ctrl_second_reg_write_in;
        events[KBD_GATE_BIT] = kbd_gate_line_change_in;
        events[LEGACY_XFER_BIT] = legacy_transfer_event_in;
        events[LOWPIN_BIT] = lowpin_bus_event_in;
        events[SERIAL_B_BIT] = serial_b_event_in;
        events[SERIAL_A_BIT] = serial_a_event_in;
        events[FAST_INIT_BIT] = fast_port_init_in;
        events[FAST_GATE_BIT] = fast_port_gate_change_in;
        events[KBD_INIT_BIT] = kbd_init_sequence_in;
        events[POWER_LOGIC_BIT] = power_logic_event_in;
        events[IRQ_MAPPER_BIT] = irq_mapper_event_in;
        events[KBD_EMU_BIT] = kbd_emulation_event_in;
        events[SHUTDOWN_BIT] = shutdown_cycle_in;
        events[HALT_BIT] = halt_cycle_in;
    end

    // Reserved enables are never stored, so they read zero
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable_q <= REG_RESET[SRC_W-1:0];
        end else if (reg_req_in.write) begin
            enable_q <= reg_req_in.data[SRC_W-1:0] & ENABLE_MASK;
        end
    end

    assign clears = reg_req_in.write ?
        (reg_req_in.data[FLAG_LSB +: SRC_W] & ENABLE_MASK) : '0;

    genvar i;
    generate
        for (i = 0; i < SRC_W; i++) begin : g_flag
            if (ENABLE_MASK[i]) begin : g_impl
                smi_flag_cell u_cell (
                    .clock_in(clock_in),
                    .rstn_in(rstn_in),
                    .enable_in(enable_q[i]),
                    .event_in(events[i]),
                    .clear_in(clears[i]),
                    .flag_out(flags[i])
                );
            end else begin : g_rsvd
                assign flags[i] = 1'b0;
            end
        end
    endgenerate

    assign reg_rdata_out = {16'h0000, flags, 16'h0000, enable_q};

    // Registered indications follow flags; clearing the flag drops them
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_q <= '0;
        end else begin
            irq_q.sync_mgmt_interrupt <= any_pending(flags, enable_q, SYNC_MASK);
            irq_q.async_mgmt_interrupt <= any_pending(flags, enable_q, ASYNC_MASK);
        end
    end

    assign irq_out = irq_q;

    property p_set_on_event;
        @(posedge clock_in) disable iff (!rstn_in)
            (halt_cycle_in && enable_q[HALT_BIT]) |=> flags[HALT_BIT];
    endproperty
    a_set_on_event: assert property (p_set_on_event) else $error("halt flag not set");

    property p_no_set_disabled;
        @(posedge clock_in) disable iff (!rstn_in)
            !enable_q[SHUTDOWN_BIT]
            |=> !$rose(flags[SHUTDOWN_BIT]);
    endproperty
    a_no_set_disabled: assert property (p_no_set_disabled) else $error("flag set while disabled");

    property p_clear;
        @(posedge clock_in) disable iff (!rstn_in)
            (reg_req_in.write && reg_req_in.data[FLAG_LSB + PWR_FIRST_BIT]
             && !power_ctrl_first_reg_write_in) |=> !flags[PWR_FIRST_BIT];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_sticky;
        @(posedge clock_in) disable iff (!rstn_in)
            (flags[SERIAL_A_BIT] && !(reg_req_in.write && reg_req_in.data[FLAG_LSB + SERIAL_A_BIT]))
            |=> flags[SERIAL_A_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_reserved;
        @(posedge clock_in) disable iff (!rstn_in)
            reg_rdata_out[63:48] == 16'h0000 && reg_rdata_out[31:16] == 16'h0000
            && !reg_rdata_out[42] && !reg_rdata_out[10];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_sync_irq;
        @(posedge clock_in) disable iff (!rstn_in)
            (flags[PWR_SECOND_BIT] && enable_q[PWR_SECOND_BIT]) |=> irq_out.sync_mgmt_interrupt;
    endproperty
    a_sync_irq: assert property (p_sync_irq) else $error("sync indication missing");

    property p_async_irq;
        @(posedge clock_in) disable iff (!rstn_in)
            (kbd_gate_line_change_in && enable_q[KBD_GATE_BIT])
            ##1 enable_q[KBD_GATE_BIT] |=> irq_out.async_mgmt_interrupt;
    endproperty
    a_async_irq: assert property (p_async_irq) else $error("async indication missing");

    property p_irq_quiet;
        @(posedge clock_in) disable iff (!rstn_in)
            ((flags & enable_q) == 16'h0000) |=> !irq_out.sync_mgmt_interrupt
            && !irq_out.async_mgmt_interrupt;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("indication without flag");

    property p_no_spurious_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (flags == '0 && (events & enable_q) == '0) |=> flags == '0;
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set)
        else $error("flag set with no enabled event");

    property p_enable_write;
        @(posedge clock_in) disable iff (!rstn_in)
            reg_req_in.write
            |=> enable_q == ($past(reg_req_in.data[SRC_W-1:0]) & ENABLE_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable write did not land");

    property p_pwr_first_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (power_ctrl_first_reg_write_in && enable_q[PWR_FIRST_BIT])
            |=> flags[PWR_FIRST_BIT];
    endproperty
    a_pwr_first_set: assert property (p_pwr_first_set)
        else $error("first power control flag not set");

    property p_pwr_second_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (power_ctrl_second_reg_write_in && enable_q[PWR_SECOND_BIT])
            |=> flags[PWR_SECOND_BIT];
    endproperty
    a_pwr_second_set: assert property (p_pwr_second_set)
        else $error("second power control flag not set");

    property p_kbd_gate_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (kbd_gate_line_change_in && enable_q[KBD_GATE_BIT])
            |=> flags[KBD_GATE_BIT];
    endproperty
    a_kbd_gate_set: assert property (p_kbd_gate_set)
        else $error("keyboard gate flag not set");

    property p_legacy_xfer_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (legacy_transfer_event_in && enable_q[LEGACY_XFER_BIT])
            |=> flags[LEGACY_XFER_BIT];
    endproperty
    a_legacy_xfer_set: assert property (p_legacy_xfer_set)
        else $error("legacy transfer flag not set");

    property p_lowpin_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (lowpin_bus_event_in && enable_q[LOWPIN_BIT])
            |=> flags[LOWPIN_BIT];
    endproperty
    a_lowpin_set: assert property (p_lowpin_set)
        else $error("low pin count bus flag not set");

    property p_serial_b_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (serial_b_event_in && enable_q[SERIAL_B_BIT])
            |=> flags[SERIAL_B_BIT];
    endproperty
    a_serial_b_set: assert property (p_serial_b_set)
        else $error("second serial flag not set");

    property p_serial_a_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (serial_a_event_in && enable_q[SERIAL_A_BIT])
            |=> flags[SERIAL_A_BIT];
    endproperty
    a_serial_a_set: assert property (p_serial_a_set)
        else $error("first serial flag not set");

    property p_fast_init_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (fast_port_init_in && enable_q[FAST_INIT_BIT])
            |=> flags[FAST_INIT_BIT];
    endproperty
    a_fast_init_set: assert property (p_fast_init_set)
        else $error("fast port init flag not set");

    property p_fast_gate_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (fast_port_gate_change_in && enable_q[FAST_GATE_BIT])
            |=> flags[FAST_GATE_BIT];
    endproperty
    a_fast_gate_set: assert property (p_fast_gate_set)
        else $error("fast port gate flag not set");

    property p_kbd_init_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (kbd_init_sequence_in && enable_q[KBD_INIT_BIT])
            |=> flags[KBD_INIT_BIT];
    endproperty
    a_kbd_init_set: assert property (p_kbd_init_set)
        else $error("keyboard init flag not set");

    property p_power_logic_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (power_logic_event_in && enable_q[POWER_LOGIC_BIT])
            |=> flags[POWER_LOGIC_BIT];
    endproperty
    a_power_logic_set: assert property (p_power_logic_set)
        else $error("power logic flag not set");

    property p_irq_mapper_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (irq_mapper_event_in && enable_q[IRQ_MAPPER_BIT])
            |=> flags[IRQ_MAPPER_BIT];
    endproperty
    a_irq_mapper_set: assert property (p_irq_mapper_set)
        else $error("interrupt mapper flag not set");

    property p_kbd_emu_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (kbd_emulation_event_in && enable_q[KBD_EMU_BIT])
            |=> flags[KBD_EMU_BIT];
    endproperty
    a_kbd_emu_set: assert property (p_kbd_emu_set)
        else $error("keyboard emulation flag not set");

    property p_shutdown_set;
        @(posedge clock_in) disable iff (!rstn_in)
            (shutdown_cycle_in && enable_q[SHUTDOWN_BIT])
            |=> flags[SHUTDOWN_BIT];
    endproperty
    a_shutdown_set: assert property (p_shutdown_set)
        else $error("shutdown flag not set");
endmodule // smi_event_flag_control

// File: dv/smi_handler_model.sv
// Processor-side handler model: counts entries per management interrupt kind.
// Assumes both indications are registered levels on clock_in.
`timescale 1ns/100ps
module smi_handler_model
    import smi_flag_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Indications
    input wire mgmt_irq_t irq_in,
    // Entry counts
    output logic [7:0] sync_count_out,
    output logic [7:0] async_count_out
);
    mgmt_irq_t last_q;

    // A held level is one entry only, so count rising edges
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_q <= '0;
            sync_count_out <= '0;
            async_count_out <= '0;
        end else begin
            last_q <= irq_in;
            if (irq_in.sync_mgmt_interrupt && !last_q.sync_mgmt_interrupt)
                sync_count_out <= sync_count_out + 8'h01;
            if (irq_in.async_mgmt_interrupt && !last_q.async_mgmt_interrupt)
                async_count_out <= async_count_out + 8'h01;
        end
    end
endmodule // smi_handler_model

// File: dv/tb_smi_event_flag_control.sv
// Testbench for the management interrupt event flag register.
// Assumes combinational reads, flags one edge after an event, indications one later.
`timescale 1ns/100ps
module tb_smi_event_flag_control
    import smi_flag_pkg::*;
;
    logic clock_in;
    logic rstn_in;
    reg_req_t req;
    logic [15:0] ev;
    logic [63:0] rdata;
    mgmt_irq_t irq;
    logic [7:0] sync_cnt;
    logic [7:0] async_cnt;
    int fails;
    int total_checks;
    int n;

    smi_event_flag_control dut (
        .clock_in(clock_in), .rstn_in(rstn_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .power_ctrl_first_reg_write_in(ev[15]), .power_ctrl_second_reg_write_in(ev[14]),
        .kbd_gate_line_change_in(ev[13]), .legacy_transfer_event_in(ev[12]),
        .lowpin_bus_event_in(ev[11]), .serial_b_event_in(ev[9]), .serial_a_event_in(ev[8]),
        .fast_port_init_in(ev[7]), .fast_port_gate_change_in(ev[6]),
        .kbd_init_sequence_in(ev[5]), .power_logic_event_in(ev[4]),
        .irq_mapper_event_in(ev[3]), .kbd_emulation_event_in(ev[2]),
        .shutdown_cycle_in(ev[1]), .halt_cycle_in(ev[0]), .irq_out(irq));

    smi_handler_model host (.clock_in(clock_in), .rstn_in(rstn_in), .irq_in(irq),
        .sync_count_out(sync_cnt), .async_count_out(async_cnt));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [63:0] d);
        req = '{write: 1'b1, data: d};
        tick(1);
        req.write = 1'b0;
        // Idle edge so a following write never re-raises the strobe in this step
        tick(1);
    endtask

    task automatic pulse(input int b);
        ev[b] = 1'b1;
        tick(1);
        ev[b] = 1'b0;
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock_in);
        fails++;
        give_verdict;
    end

    initial begin
        fails = 0;
        total_checks = 0;
        ev = '0;
        req = '0;
        rstn_in = 1'b0;
        tick(10);
        rstn_in = 1'b1;
        chk(rdata, REG_RESET);
        wr(64'hffff_ffff_ffff_ffff);
        chk(rdata, 64'h0000_0000_0000_fbff);
        for (n = 0; n < 16; n++) begin
            if (n == 10)
                continue;
            // Every other source enabled, so a crossed enable shows up here
            wr(64'hffff_ffff_0000_0000 | {48'h0, ENABLE_MASK & ~(16'h1 << n)});
            pulse(n);
            tick(1);
            chk(rdata, {48'h0, ENABLE_MASK & ~(16'h1 << n)});
            chk({62'h0, irq}, 64'h0);
            wr(64'h1 << n);
            pulse(n);
            tick(1);
            chk(rdata, (64'h1 << (n + 32)) | (64'h1 << n));
            chk(rdata, (64'h1 << (n + 32)) | (64'h1 << n));
            chk(rdata, (64'h1 << (n + 32)) | (64'h1 << n));
            chk(rdata, (64'h1 << (n + 32)) | (64'h1 << n));
            tick(3);
            chk({62'h0, irq}, {62'h0, SYNC_MASK[n], ASYNC_MASK[n]});
            wr(64'h0);
            tick(1);
            chk(rdata, 64'h1 << (n + 32));
            chk({62'h0, irq}, 64'h0);
            wr(64'h1 << (n + 32));
            chk(rdata, 64'h0);
        end
        chk({56'h0, sync_cnt}, 64'h6);
        chk({56'h0, async_cnt}, 64'h9);
        wr(64'h1);
        tick(1);
        // Event and clear in one cycle: the new event must survive
        req = '{write: 1'b1, data: 64'h0000_0001_0000_0001};
        ev[HALT_BIT] = 1'b1;
        tick(1);
        req.write = 1'b0;
        ev[HALT_BIT] = 1'b0;
        chk(rdata, 64'h0000_0001_0000_0001);
        give_verdict;
    end
endmodule // tb_smi_event_flag_control
